// ===== branch_unit_pkg.sv
// Shared constants for the conditional branch unit.
package branch_unit_pkg;
   localparam int          INSTR_W        = 16;
   localparam int          PC_W           = 21;
   localparam int          OFFSET_W       = 8;
   localparam logic [3:0]  GROUP_CODE     = 4'hE;
   localparam logic [3:0]  SUB_CARRY_CLR  = 4'h3;
   localparam logic [3:0]  SUB_NEG_CLR    = 4'h7;
   localparam logic [3:0]  SUB_OVF_CLR    = 4'h5;
   localparam logic [3:0]  SUB_NEG_SET    = 4'h6;
   localparam logic [20:0] FETCH_STEP     = 21'h000002;
   localparam logic [20:0] PC_RESET       = 21'h000000;
   localparam logic [1:0]  Q1             = 2'h0;
   localparam logic [1:0]  Q2             = 2'h1;
   localparam logic [1:0]  Q3             = 2'h2;
   localparam logic [1:0]  Q4             = 2'h3;
   localparam real         CLK_PERIOD_NS  = 10.0;
endpackage

// ===== branch_target_adder.sv
// Target adder: incremented address plus doubled signed offset.
`timescale 1ns/100ps
module branch_target_adder
   import branch_unit_pkg::*;
#(
   parameter int PCW = PC_W
)
(
   // Operands
   input  wire logic [PCW-1:0]      pc_i,
   input  wire logic [OFFSET_W-1:0] offset_i,
   // Result
   output logic      [PCW-1:0]      target_o
);
   // The sign extension below needs at least one copy of the sign bit.
   if (PCW < OFFSET_W + 2)
   begin : g_width_check
      $error("PC width too small for branch reach");
   end

   logic [PCW-1:0] doubled;

   // Sign extension keeps the whole -128..127 range, then shift doubles it.
   assign doubled  = {{(PCW-OFFSET_W-1){offset_i[OFFSET_W-1]}}, offset_i, 1'b0}; // [RL5] [RL7]
   assign target_o = pc_i + PCW'(FETCH_STEP) + doubled; // [RL6]
endmodule

// ===== conditional_branch_unit.sv
// Conditional branch decode and execute unit with quarter-phase sequencing.
// What this block does
// [RL1] Carry-clear branch (E,3,offset) is taken only when carry is zero.
// [RL2] Negative-clear branch (E,7,offset) is taken only when negative is zero.
// [RL3] Overflow-clear branch (E,5,offset) is taken only when overflow is zero.
// [RL4] Negative-set branch (E,6,offset) is taken only when negative is one.
// [RL5] The offset is signed two's complement and is doubled before adding.
// [RL6] A taken branch loads the instruction address plus 2 plus twice the offset.
// [RL7] Offsets from -128 to 127 are all reachable.
// [RL8] Not taken costs one instruction cycle, taken costs two.
// [RL9] Q1 decode, Q2 read offset, Q3 process, Q4 write PC if taken; then one idle cycle.
// [RL10] The status flags are never altered by these branches.
// [RL11] In the idle cycle the prefetched sequential word is flushed and the target refetched.
`timescale 1ns/100ps
module conditional_branch_unit
   import branch_unit_pkg::*;
(
   // Clock and reset
   input  wire logic               CLK_I,
   input  wire logic               RESET_N_I,
   // Instruction from fetch, valid for a whole instruction cycle
   input  wire logic [INSTR_W-1:0] INSTR_I,
   input  wire logic [PC_W-1:0]    INSTR_ADDR_I,
   input  wire logic               INSTR_VALID_I,
   // Status flags from the core
   input  wire logic               CARRY_I,
   input  wire logic               NEGATIVE_I,
   input  wire logic               OVERFLOW_I,
   // Program counter and fetch control
   output logic [PC_W-1:0]         PC_O,
   output logic                    PC_WRITE_O,
   output logic                    FLUSH_O,
   output logic                    IDLE_CYCLE_O,
   output logic [1:0]              QUARTER_O,
   output logic                    TAKEN_O,
   // Flags pass through untouched
   output logic                    CARRY_O,
   output logic                    NEGATIVE_O,
   output logic                    OVERFLOW_O
);
   typedef enum {EXEC, IDLE} cyc_e;

   cyc_e             cyc_reg;
   logic [1:0]       q_reg;
   logic             is_branch_reg;
   logic             cond_reg;
   logic [7:0]       offset_reg;
   logic [PC_W-1:0]  addr_reg;
   logic [PC_W-1:0]  target;
   logic [3:0]       sub_code;
   logic             is_branch_next;
   logic             cond_next;

   // Quarter phase counter: each clock is one quarter.
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
         q_reg <= Q1;
      else
         q_reg <= q_reg + 2'h1;
   end

   // Q1 decode of the four conditional branch encodings.
   assign sub_code = INSTR_I[11:8];
   always_comb
   begin
      is_branch_next = 1'b0;
      cond_next      = 1'b0;
      if (INSTR_VALID_I && INSTR_I[15:12] == GROUP_CODE)
      begin
         case (sub_code)
            SUB_CARRY_CLR:
            begin
               is_branch_next = 1'b1;
               cond_next      = !CARRY_I; // [RL1]
            end
            SUB_NEG_CLR:
            begin
               is_branch_next = 1'b1;
               cond_next      = !NEGATIVE_I; // [RL2]
            end
            SUB_OVF_CLR:
            begin
               is_branch_next = 1'b1;
               cond_next      = !OVERFLOW_I; // [RL3]
            end
            SUB_NEG_SET:
            begin
               is_branch_next = 1'b1;
               cond_next      = NEGATIVE_I; // [RL4]
            end
            default:
            begin
               is_branch_next = 1'b0;
               cond_next      = 1'b0;
            end
         endcase
      end
   end

   // Decode in Q1, capture the offset in Q2, evaluate the flag in Q3.
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         is_branch_reg <= 1'b0;
         cond_reg      <= 1'b0;
         offset_reg    <= 8'h00;
         addr_reg      <= PC_RESET;
      end
      else if (cyc_reg == EXEC)
      begin
         case (q_reg)
            Q1:
            begin
               is_branch_reg <= is_branch_next; // [RL9]
               addr_reg      <= INSTR_ADDR_I;
            end
            Q2:
               offset_reg <= INSTR_I[7:0]; // [RL9]
            Q3:
               cond_reg <= is_branch_reg && cond_next; // [RL9]
            default:
               cond_reg <= cond_reg;
         endcase
      end
   end

   branch_target_adder #(.PCW(PC_W)) u_adder
   (
      .pc_i     (addr_reg),
      .offset_i (offset_reg),
      .target_o (target)
   );

   // Instruction cycle state: a taken branch inserts one idle cycle.
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
         cyc_reg <= EXEC;
      else if (q_reg == Q4)
      begin
         case (cyc_reg)
            EXEC:    cyc_reg <= cond_reg ? IDLE : EXEC; // [RL8]
            IDLE:    cyc_reg <= EXEC;
            default: cyc_reg <= EXEC;
         endcase
      end
   end

   // Q4 writes the target when taken; nothing happens otherwise.
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         PC_O       <= PC_RESET;
         PC_WRITE_O <= 1'b0;
      end
      else
      begin
         PC_WRITE_O <= (cyc_reg == EXEC) && (q_reg == Q4) && cond_reg; // [RL9]
         if ((cyc_reg == EXEC) && (q_reg == Q4) && cond_reg)
            PC_O <= target; // [RL6]
      end
   end

   // Idle cycle marking and flush of the sequential prefetch.
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         FLUSH_O      <= 1'b0;
         IDLE_CYCLE_O <= 1'b0;
         TAKEN_O      <= 1'b0;
         QUARTER_O    <= Q1;
      end
      else
      begin
         FLUSH_O      <= (cyc_reg == EXEC) && (q_reg == Q4) && cond_reg; // [RL11]
         IDLE_CYCLE_O <= (q_reg == Q4) ? ((cyc_reg == EXEC) && cond_reg)
                                       : (cyc_reg == IDLE); // [RL8]
         TAKEN_O      <= (q_reg == Q4) ? 1'b0 : (cyc_reg == EXEC) && (q_reg == Q3)
                                                ? (is_branch_reg && cond_next) : TAKEN_O;
         QUARTER_O    <= q_reg + 2'h1;
      end
   end

   // Flags are only forwarded, so a branch can never change them.
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         CARRY_O    <= 1'b0;
         NEGATIVE_O <= 1'b0;
         OVERFLOW_O <= 1'b0;
      end
      else
      begin
         CARRY_O    <= CARRY_I; // [RL10]
         NEGATIVE_O <= NEGATIVE_I;
         OVERFLOW_O <= OVERFLOW_I;
      end
   end

   a_taken_writes_pc: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL6]
      (cyc_reg == EXEC && q_reg == Q4 && cond_reg) |=> (PC_WRITE_O && PC_O == $past(target)))
      else $error("taken branch did not load target");

   a_untaken_no_write: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL9]
      (q_reg == Q4 && !cond_reg) |=> !PC_WRITE_O)
      else $error("untaken branch wrote the PC");

   sequence s_taken_q4;
      cyc_reg == EXEC && q_reg == Q4 && cond_reg;
   endsequence

   a_idle_four_quarters: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL8]
      s_taken_q4 |=> (cyc_reg == IDLE)[*4] ##1 (cyc_reg == EXEC))
      else $error("idle cycle not exactly four quarters");

   a_flush_with_write: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL11]
      (FLUSH_O == PC_WRITE_O) && (!FLUSH_O || IDLE_CYCLE_O))
      else $error("flush not paired with PC write");

   a_no_write_in_idle: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL8]
      (cyc_reg == IDLE) |=> !PC_WRITE_O)
      else $error("PC written during idle cycle");

   a_carry_clear_cond: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL1]
      (cyc_reg == EXEC && q_reg == Q3 && is_branch_reg && sub_code == SUB_CARRY_CLR
       && INSTR_I[15:12] == GROUP_CODE && INSTR_VALID_I) |=> (cond_reg == !$past(CARRY_I)))
      else $error("carry-clear condition wrong");

   a_neg_set_cond: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL4]
      (cyc_reg == EXEC && q_reg == Q3 && is_branch_reg && sub_code == SUB_NEG_SET
       && INSTR_I[15:12] == GROUP_CODE && INSTR_VALID_I) |=> (cond_reg == $past(NEGATIVE_I)))
      else $error("negative-set condition wrong");

   a_flags_unchanged: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL10]
      ##1 (CARRY_O == $past(CARRY_I) && NEGATIVE_O == $past(NEGATIVE_I)
           && OVERFLOW_O == $past(OVERFLOW_I)))
      else $error("status flag altered");

   a_target_math: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // [RL5]
      target == addr_reg + FETCH_STEP + {{12{offset_reg[7]}}, offset_reg, 1'b0})
      else $error("branch target arithmetic wrong");
endmodule

// ===== conditional_branch_unit_tb.sv
// Self-checking testbench for the conditional branch unit.
`timescale 1ns/100ps
module conditional_branch_unit_tb import branch_unit_pkg::*;;
   // About three times the 122 cycles that the scenarios need.
   localparam int      WATCHDOG_CYCLES = 400;

   logic               clk;
   logic               reset_n;
   logic [INSTR_W-1:0] instr;
   logic [PC_W-1:0]    addr;
   logic               valid;
   logic               carry;
   logic               neg;
   logic               ovf;
   logic [PC_W-1:0]    pc;
   logic               pc_write;
   logic               flush;
   logic               idle;
   logic [1:0]         quarter;
   logic               taken;
   logic               carry_q;
   logic               neg_q;
   logic               ovf_q;
   logic [PC_W-1:0]    exp_pc;
   int                 n_mismatch;
   int                 n_checks;

   conditional_branch_unit u_dut
   (
      .CLK_I         (clk),
      .RESET_N_I     (reset_n),
      .INSTR_I       (instr),
      .INSTR_ADDR_I  (addr),
      .INSTR_VALID_I (valid),
      .CARRY_I       (carry),
      .NEGATIVE_I    (neg),
      .OVERFLOW_I    (ovf),
      .PC_O          (pc),
      .PC_WRITE_O    (pc_write),
      .FLUSH_O       (flush),
      .IDLE_CYCLE_O  (idle),
      .QUARTER_O     (quarter),
      .TAKEN_O       (taken),
      .CARRY_O       (carry_q),
      .NEGATIVE_O    (neg_q),
      .OVERFLOW_O    (ovf_q)
   );

   initial
   begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
   end

   task automatic check(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] expected,
                        input string what);
      n_checks++;
      if (seen !== expected)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Runs one instruction cycle and the cycle after it; f is {carry, negative, overflow}.
   // It is called in the time step of a rising edge, so that the next edge is a Q1 edge.
   // With v low the word is squashed. With keep high another branch word that would be
   // taken stays valid through the idle cycle, where it must be ignored.
   task automatic run(input logic [3:0] sub, input logic [7:0] off, input logic [PC_W-1:0] a,
                      input logic [2:0] f, input logic v, input logic t, input logic keep);
      logic [PC_W-1:0] tgt;
      tgt = a + FETCH_STEP + {{(PC_W-9){off[7]}}, off, 1'b0};
      instr <= {GROUP_CODE, sub, off};
      addr  <= a;
      valid <= v;
      {carry, neg, ovf} <= f;
      repeat (3) @(posedge clk);
      #1;
      check(PC_W'({taken, pc_write}), PC_W'({t, 1'b0}), "condition decision");
      check(pc, exp_pc, "PC held before Q4");
      @(posedge clk);
      valid <= keep;
      instr <= {GROUP_CODE, sub, ~off};
      addr  <= a + 21'h000100;
      #1;
      if (t)
         exp_pc = tgt;
      check(PC_W'({pc_write, flush, idle}), PC_W'({3{t}}), "branch strobes");
      check(pc, exp_pc, "program counter");
      check(PC_W'({carry_q, neg_q, ovf_q}), PC_W'(f), "flags altered");
      check(PC_W'(quarter), PC_W'(Q1), "quarter after Q4");
      repeat (3)
      begin
         @(posedge clk);
         #1;
         check(PC_W'({pc_write, flush, idle}), PC_W'({2'b00, t}), "idle cycle");
         check(pc, exp_pc, "PC during idle");
      end
      check(PC_W'(quarter), PC_W'(Q4), "quarter sequence");
      @(posedge clk);
   endtask

   task automatic t_carry_clear;
      run(SUB_CARRY_CLR, 8'h05, 21'h000100, 3'b011, 1'b1, 1'b1, 1'b0);
      run(SUB_CARRY_CLR, 8'h05, 21'h000200, 3'b100, 1'b1, 1'b0, 1'b0);
      $display("Test carry clear done");
   endtask

   task automatic t_neg_clear;
      run(SUB_NEG_CLR, 8'h10, 21'h000300, 3'b101, 1'b1, 1'b1, 1'b0);
      run(SUB_NEG_CLR, 8'h10, 21'h000400, 3'b010, 1'b1, 1'b0, 1'b0);
      $display("Test negative clear done");
   endtask

   task automatic t_ovf_clear;
      run(SUB_OVF_CLR, 8'hFE, 21'h000500, 3'b110, 1'b1, 1'b1, 1'b0);
      run(SUB_OVF_CLR, 8'hFE, 21'h000600, 3'b001, 1'b1, 1'b0, 1'b0);
      $display("Test overflow clear done");
   endtask

   task automatic t_neg_set;
      run(SUB_NEG_SET, 8'h21, 21'h000700, 3'b010, 1'b1, 1'b1, 1'b0);
      run(SUB_NEG_SET, 8'h21, 21'h000800, 3'b101, 1'b1, 1'b0, 1'b0);
      $display("Test negative set done");
   endtask

   task automatic t_offset_bounds;
      run(SUB_CARRY_CLR, 8'h80, 21'h001000, 3'b000, 1'b1, 1'b1, 1'b0);
      run(SUB_CARRY_CLR, 8'h7F, 21'h001000, 3'b000, 1'b1, 1'b1, 1'b0);
      run(SUB_CARRY_CLR, 8'h00, 21'h1FFFFE, 3'b000, 1'b1, 1'b1, 1'b0);
      $display("Test offset bounds done");
   endtask

   task automatic t_other_code;
      run(4'h2, 8'h40, 21'h002000, 3'b000, 1'b1, 1'b0, 1'b0);
      run(SUB_CARRY_CLR, 8'h40, 21'h002100, 3'b000, 1'b0, 1'b0, 1'b0);
      $display("Test other code done");
   endtask

   // The untaken run after the refused word shows that nothing was written late.
   task automatic t_refused;
      run(SUB_NEG_CLR, 8'h33, 21'h003000, 3'b000, 1'b1, 1'b1, 1'b1);
      run(SUB_NEG_CLR, 8'h33, 21'h003200, 3'b010, 1'b1, 1'b0, 1'b0);
      $display("Test idle refusal done");
   endtask

   initial
   begin
      repeat (WATCHDOG_CYCLES) @(posedge clk);
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      n_mismatch = 0;
      n_checks   = 0;
      exp_pc     = PC_RESET;
      reset_n    = 1'b0;
      instr      = '0;
      addr       = '0;
      valid      = 1'b0;
      {carry, neg, ovf} = 3'b000;
      @(posedge clk);
      #1;
      check(pc, PC_RESET, "reset value");
      check(PC_W'({pc_write, flush, idle, taken, quarter}), PC_W'(6'h00), "reset strobes");
      @(posedge clk);
      reset_n <= 1'b1;
      t_carry_clear();
      t_neg_clear();
      t_ovf_clear();
      t_neg_set();
      t_offset_bounds();
      t_other_code();
      t_refused();
      end_sim();
   end
endmodule
